// [verilog/fault_softstart_output_limiter.sv]
// Function
// - During input fault, both outputs take their own configured fault values.
// - After power-on, primary output is capped at the soft-start limit.
// - Duration held as hours and minutes; zero disables the clamp.
// - Once the duration has elapsed the clamp is released.
// - Manual value overrides the clamp; the timer keeps counting.
// - No soft-start clamp when two control outputs are configured.
// - Long choose shows tuning group; arrows pick group; choose enters setup.
// - Choose starts edit with the display blinking; arrows step the value; choose stores.
`timescale 1ns/10ps

module fault_softstart_output_limiter #(
  parameter logic [31:0] MINUTE_COUNT = 32'(limiter_pkg::MINUTE_CYCLES),
  parameter logic [31:0] LONG_PRESS_COUNT = 32'(limiter_pkg::LONG_PRESS_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Front-panel keys, asynchronous
  input wire limiter_pkg::keys_t keys,
  // Process state, asynchronous fault flag
  input wire logic input_fault_state,
  input wire logic dual_output,
  input wire logic manual_mode,
  input wire limiter_pkg::pct_t manual_value,
  input wire limiter_pkg::pct_t normal_primary,
  input wire limiter_pkg::pct_t normal_secondary,
  input wire logic [12:0] measured_input_type,
  // Actuator outputs
  output limiter_pkg::pct_t primary_control_output,
  output limiter_pkg::pct_t secondary_control_output,
  output logic soft_start_active,
  // Display
  output limiter_pkg::display_t display,
  output limiter_pkg::settings_t settings
);
  import limiter_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] sync_prev;
  keys_t key_now;
  keys_t key_prev;
  keys_t key_edge;
  logic fault_now;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sync_prev <= 5'h00;
    end else begin
      sync_a <= {keys, input_fault_state};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  always_comb begin
    key_now = sync_b[4:1];
    key_prev = sync_prev[4:1];
    key_edge = key_now & ~key_prev;
    fault_now = sync_b[0];
  end

  // ----------------------------------------------------------------
  // Soft-start timer
  // ----------------------------------------------------------------
  // The timer runs from reset regardless of mode, so manual operation
  // does not stretch the soft-start window.
  logic [31:0] minute_count;
  logic [31:0] next_minute_count;
  duration_t elapsed;
  duration_t next_elapsed;
  logic next_soft_start_active;

  always_comb begin
    next_minute_count = minute_count + 32'h00000001;
    next_elapsed = elapsed;
    if (minute_count == MINUTE_COUNT - 32'h00000001) begin
      next_minute_count = 32'h00000000;
      if (elapsed.minutes == MINUTES_MAX) begin
        if (elapsed.hours != HOURS_MAX) begin
          next_elapsed.minutes = 6'h00;
          next_elapsed.hours = elapsed.hours + 7'h01;
        end
      end else begin
        next_elapsed.minutes = elapsed.minutes + 6'h01;
      end
    end
    next_soft_start_active = (settings.soft_start_duration != DURATION_ZERO)
      && (next_elapsed < settings.soft_start_duration)
      && !dual_output;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      minute_count <= 32'h00000000;
      elapsed <= DURATION_ZERO;
      soft_start_active <= 1'b0;
    end else begin
      minute_count <= next_minute_count;
      elapsed <= next_elapsed;
      soft_start_active <= next_soft_start_active;
    end
  end

  // ----------------------------------------------------------------
  // Output override
  // ----------------------------------------------------------------
  pct_t next_primary;
  pct_t next_secondary;

  always_comb begin
    next_secondary = normal_secondary;
    if (fault_now) begin
      next_primary = settings.fault_primary_value;
      next_secondary = settings.fault_secondary_value;
    end else if (manual_mode) begin
      next_primary = manual_value;
    end else if (soft_start_active && normal_primary > settings.soft_start_primary_limit) begin
      next_primary = settings.soft_start_primary_limit;
    end else begin
      next_primary = normal_primary;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      primary_control_output <= PCT_MIN;
      secondary_control_output <= PCT_MIN;
    end else begin
      primary_control_output <= next_primary;
      secondary_control_output <= next_secondary;
    end
  end

  // ----------------------------------------------------------------
  // Front-panel menu
  // ----------------------------------------------------------------
  menu_t menu;
  menu_t next_menu;
  logic [2:0] group;
  logic [2:0] next_group;
  param_t param;
  param_t next_param;
  logic [12:0] edit_value;
  logic [12:0] next_edit_value;
  logic [31:0] hold_count;
  logic [31:0] next_hold_count;
  settings_t next_settings;
  display_t next_display;
  logic [12:0] shown_value;

  function automatic logic [12:0] step_value(param_t p, logic [12:0] v, logic up);
    pct_t pct;
    duration_t dur;
    pct = pct_t'(v[11:0]);
    dur = duration_t'(v);
    if (p == PARAM_SOFT_DURATION) begin
      if (up) begin
        if (dur.minutes != MINUTES_MAX) begin
          dur.minutes = dur.minutes + 6'h01;
        end else if (dur.hours != HOURS_MAX) begin
          dur.minutes = 6'h00;
          dur.hours = dur.hours + 7'h01;
        end
      end else begin
        if (dur.minutes != 6'h00) begin
          dur.minutes = dur.minutes - 6'h01;
        end else if (dur.hours != 7'h00) begin
          dur.minutes = MINUTES_MAX;
          dur.hours = dur.hours - 7'h01;
        end
      end
      return 13'(dur);
    end
    // Clamping here keeps a stored value inside the legal output range
    if (up && pct < PCT_MAX) begin
      pct = pct + PCT_STEP;
    end else if (!up && pct > PCT_MIN) begin
      pct = pct - PCT_STEP;
    end
    return {pct[11], pct};
  endfunction : step_value

  always_comb begin
    unique case (param)
      PARAM_INPUT_TYPE: shown_value = measured_input_type;
      PARAM_FAULT_PRIMARY: shown_value = {settings.fault_primary_value[11],
        settings.fault_primary_value};
      PARAM_FAULT_SECONDARY: shown_value = {settings.fault_secondary_value[11],
        settings.fault_secondary_value};
      PARAM_SOFT_LIMIT: shown_value = {settings.soft_start_primary_limit[11],
        settings.soft_start_primary_limit};
      PARAM_SOFT_DURATION: shown_value = 13'(settings.soft_start_duration);
      default: shown_value = 13'h0000;
    endcase
  end

  always_comb begin
    next_menu = menu;
    next_group = group;
    next_param = param;
    next_edit_value = edit_value;
    next_settings = settings;
    next_hold_count = key_now.choose ? hold_count + 32'h00000001 : 32'h00000000;
    if (hold_count == LONG_PRESS_COUNT) begin
      next_hold_count = hold_count;
    end
    unique case (menu)
      MENU_RUN: begin
        if (key_now.choose && hold_count == LONG_PRESS_COUNT - 32'h00000001) begin
          next_menu = MENU_GROUP;
          next_group = GROUP_TUNING;
        end
      end
      MENU_GROUP: begin
        if (key_edge.back) begin
          next_menu = MENU_RUN;
        end else if (key_edge.up) begin
          next_group = (group == GROUP_SETUP) ? GROUP_TUNING : group + 3'h1;
        end else if (key_edge.down) begin
          next_group = (group == GROUP_TUNING) ? GROUP_SETUP : group - 3'h1;
        end else if (key_edge.choose && group == GROUP_SETUP) begin
          next_menu = MENU_PARAM;
          next_param = PARAM_INPUT_TYPE;
        end
      end
      MENU_PARAM: begin
        if (key_edge.back) begin
          next_menu = MENU_RUN;
        end else if (key_edge.up) begin
          next_param = (param == PARAM_SOFT_DURATION) ? PARAM_INPUT_TYPE : param_t'(param + 3'h1);
        end else if (key_edge.down) begin
          next_param = (param == PARAM_INPUT_TYPE) ? PARAM_SOFT_DURATION : param_t'(param - 3'h1);
        end else if (key_edge.choose && param != PARAM_INPUT_TYPE) begin
          next_menu = MENU_EDIT;
          next_edit_value = shown_value;
        end
      end
      MENU_EDIT: begin
        if (key_edge.back) begin
          next_menu = MENU_RUN;
        end else if (key_edge.up || key_edge.down) begin
          next_edit_value = step_value(param, edit_value, key_edge.up);
        end else if (key_edge.choose) begin
          next_menu = MENU_PARAM;
          unique case (param)
            PARAM_FAULT_PRIMARY: next_settings.fault_primary_value = pct_t'(edit_value[11:0]);
            PARAM_FAULT_SECONDARY: next_settings.fault_secondary_value = pct_t'(edit_value[11:0]);
            PARAM_SOFT_LIMIT: next_settings.soft_start_primary_limit = pct_t'(edit_value[11:0]);
            PARAM_SOFT_DURATION: next_settings.soft_start_duration = duration_t'(edit_value);
            default: next_settings = settings;
          endcase
        end
      end
    endcase
    next_display.menu = next_menu;
    next_display.group = next_group;
    next_display.param = next_param;
    next_display.value = (menu == MENU_EDIT) ? edit_value : shown_value;
    next_display.blink = (next_menu == MENU_EDIT);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      menu <= MENU_RUN;
      group <= GROUP_TUNING;
      param <= PARAM_INPUT_TYPE;
      edit_value <= 13'h0000;
      hold_count <= 32'h00000000;
      settings <= {FAULT_PRIMARY_RESET, FAULT_SECONDARY_RESET, SOFT_LIMIT_RESET, DURATION_ZERO};
      display <= '0;
    end else begin
      menu <= next_menu;
      group <= next_group;
      param <= next_param;
      edit_value <= next_edit_value;
      hold_count <= next_hold_count;
      settings <= next_settings;
      display <= next_display;
    end
  end

endmodule : fault_softstart_output_limiter

// [verilog/limiter_pkg.sv]
package limiter_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 40_000_000;
  localparam longint unsigned MINUTE_S = 60;
  localparam longint unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;
  localparam longint unsigned LONG_PRESS_MS = 1000;
  localparam longint unsigned LONG_PRESS_CYCLES = LONG_PRESS_MS * CLK_HZ / 1000;

  // ----------------------------------------------------------------
  // Output values in tenths of a percent
  // ----------------------------------------------------------------
  typedef logic signed [11:0] pct_t;
  localparam pct_t PCT_MIN = 12'hFCE;
  localparam pct_t PCT_MAX = 12'h41A;
  localparam pct_t PCT_STEP = 12'h001;

  typedef struct packed {
    logic [6:0] hours;
    logic [5:0] minutes;
  } duration_t;
  localparam logic [6:0] HOURS_MAX = 7'h63;
  localparam logic [5:0] MINUTES_MAX = 6'h3B;
  localparam duration_t DURATION_ZERO = 13'h0000;

  // ----------------------------------------------------------------
  // Stored settings and their reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    pct_t fault_primary_value;
    pct_t fault_secondary_value;
    pct_t soft_start_primary_limit;
    duration_t soft_start_duration;
  } settings_t;
  localparam pct_t FAULT_PRIMARY_RESET = 12'hFCE;
  localparam pct_t FAULT_SECONDARY_RESET = 12'hFCE;
  localparam pct_t SOFT_LIMIT_RESET = 12'h41A;

  // ----------------------------------------------------------------
  // Front panel
  // ----------------------------------------------------------------
  typedef struct packed {
    logic choose;
    logic up;
    logic down;
    logic back;
  } keys_t;

  typedef enum logic [1:0] {
    MENU_RUN = 2'b00,
    MENU_GROUP = 2'b01,
    MENU_PARAM = 2'b11,
    MENU_EDIT = 2'b10
  } menu_t;

  typedef enum logic [2:0] {
    PARAM_INPUT_TYPE = 3'h0,
    PARAM_FAULT_PRIMARY = 3'h1,
    PARAM_FAULT_SECONDARY = 3'h2,
    PARAM_SOFT_LIMIT = 3'h3,
    PARAM_SOFT_DURATION = 3'h4
  } param_t;

  localparam logic [2:0] GROUP_TUNING = 3'h1;
  localparam logic [2:0] GROUP_SETUP = 3'h6;

  typedef struct packed {
    menu_t menu;
    logic [2:0] group;
    param_t param;
    logic [12:0] value;
    logic blink;
  } display_t;

endpackage : limiter_pkg

// [test/limiter_checker_sva.sv]
`timescale 1ns/10ps
module limiter_checker #(
  parameter logic [31:0] MINUTE_COUNT = 32'h0000_0014,
  parameter logic [31:0] LONG_PRESS_COUNT = 32'h0000_0008
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs
  input wire logic input_fault_state,
  input wire logic dual_output,
  input wire logic manual_mode,
  input wire limiter_pkg::pct_t manual_value,
  input wire limiter_pkg::pct_t normal_primary,
  input wire limiter_pkg::pct_t normal_secondary,
  // Outputs
  input wire limiter_pkg::pct_t primary_control_output,
  input wire limiter_pkg::pct_t secondary_control_output,
  input wire logic soft_start_active,
  input wire limiter_pkg::display_t display,
  input wire limiter_pkg::settings_t settings
);
  import limiter_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  function automatic pct_t smin(pct_t a, pct_t b);
    return (a < b) ? a : b;
  endfunction : smin
  // Three samples cover the two-stage synchroniser on the fault pin
  sequence fault_held;
    input_fault_state [*3];
  endsequence
  sequence fault_clear;
    !input_fault_state [*3];
  endsequence
  a_fault_primary: assert property (
    fault_held |=> primary_control_output == $past(settings.fault_primary_value))
    else $error("primary output not at its fault value");
  a_fault_second: assert property (
    fault_held |=> secondary_control_output == $past(settings.fault_secondary_value))
    else $error("secondary output not at its fault value");
  a_fault_release: assert property (
    fault_clear |=> secondary_control_output == $past(normal_secondary))
    else $error("secondary output not back to normal after fault");
  a_manual_wins: assert property (
    (fault_clear ##0 manual_mode) |=> primary_control_output == $past(manual_value))
    else $error("manual value not on primary output");
  // The output register reads the clamp flag as it stood at the same edge
  a_clamp_limit: assert property (
    (fault_clear ##0 !manual_mode ##0 soft_start_active) |=>
      primary_control_output == smin($past(normal_primary),
                                     $past(settings.soft_start_primary_limit)))
    else $error("primary output not clamped to soft start limit");
  a_clamp_free: assert property (
    (fault_clear ##0 !manual_mode ##0 !soft_start_active) |=>
      primary_control_output == $past(normal_primary))
    else $error("primary output limited without soft start");
  a_zero_duration: assert property (
    settings.soft_start_duration == DURATION_ZERO |=> !soft_start_active)
    else $error("soft start armed with zero duration");
  a_dual_no_clamp: assert property (
    dual_output |=> !soft_start_active)
    else $error("soft start armed with two outputs");
  a_clamp_stays_off: assert property (
    (!soft_start_active && !dual_output && !$past(dual_output) &&
     $stable(settings.soft_start_duration) && settings.soft_start_duration != DURATION_ZERO)
      |=> !soft_start_active)
    else $error("soft start armed again after it ended");
  a_enter_tuning: assert property (
    ($past(display.menu) == MENU_RUN && display.menu == MENU_GROUP) |->
      display.group == GROUP_TUNING)
    else $error("long press did not show tuning group");
endmodule : limiter_checker

bind fault_softstart_output_limiter limiter_checker #(
  .MINUTE_COUNT(MINUTE_COUNT),
  .LONG_PRESS_COUNT(LONG_PRESS_COUNT)
) u_chk (
  .clk(clk),
  .rst(rst),
  .input_fault_state(input_fault_state),
  .dual_output(dual_output),
  .manual_mode(manual_mode),
  .manual_value(manual_value),
  .normal_primary(normal_primary),
  .normal_secondary(normal_secondary),
  .primary_control_output(primary_control_output),
  .secondary_control_output(secondary_control_output),
  .soft_start_active(soft_start_active),
  .display(display),
  .settings(settings)
);

// [test/panel_model.sv]
`timescale 1ns/10ps
module panel_model (
  // Clock
  input wire logic clk,
  // Keys toward the block
  output limiter_pkg::keys_t keys
);
  import limiter_pkg::*;
  // ----------------------------------------------------------------
  // Operator key presses
  // ----------------------------------------------------------------
  initial keys = '0;
  // Long release gap so the synchroniser sees every press as a new edge
  task automatic press(logic [3:0] k, int hold);
    @(posedge clk);
    keys <= keys_t'(k);
    repeat (hold) @(posedge clk);
    keys <= '0;
    repeat (6) @(posedge clk);
    #1;
  endtask : press
endmodule : panel_model

// [test/fault_softstart_output_limiter_tb.sv]
`timescale 1ns/10ps
module fault_softstart_output_limiter_tb;
  import limiter_pkg::*;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  localparam logic [3:0] CH = 4'h8;
  localparam logic [3:0] UP = 4'h4;
  localparam logic [3:0] DN = 4'h2;
  localparam logic [3:0] BK = 4'h1;
  logic clk, rst, input_fault_state, dual_output, manual_mode, soft_start_active;
  pct_t manual_value, normal_primary, normal_secondary;
  pct_t primary_control_output, secondary_control_output;
  keys_t keys;
  display_t display;
  settings_t settings;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  panel_model u_panel (.clk(clk), .keys(keys));
  // Short minute keeps the soft start window within a brief run
  fault_softstart_output_limiter #(
    .MINUTE_COUNT(32'h0000_00C8),
    .LONG_PRESS_COUNT(32'h0000_0008)
  ) u_dut (
    .clk(clk), .rst(rst), .keys(keys), .input_fault_state(input_fault_state),
    .dual_output(dual_output), .manual_mode(manual_mode), .manual_value(manual_value),
    .normal_primary(normal_primary), .normal_secondary(normal_secondary),
    .measured_input_type(13'h0005), .primary_control_output(primary_control_output),
    .secondary_control_output(secondary_control_output),
    .soft_start_active(soft_start_active), .display(display), .settings(settings)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task check(string name, logic [12:0] seen, logic [12:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task wrap_up;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task keys_n(logic [3:0] k, int count);
    repeat (count) u_panel.press(k, 3);
  endtask : keys_n

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    input_fault_state = 1'b0;
    dual_output = 1'b0;
    manual_mode = 1'b0;
    manual_value = 12'h000;
    normal_primary = 12'h41A;
    normal_secondary = 12'h1F4;
    tick(1);
    check("fault_primary_rst", 13'(settings.fault_primary_value), 13'h1FCE);
    check("soft_limit_rst", 13'(settings.soft_start_primary_limit), 13'h041A);
    check("primary_rst", 13'(primary_control_output), 13'h1FCE);
    @(posedge clk) rst <= 1'b0;
    tick(4);
    check("active_zero", 13'(soft_start_active), 13'h0000);
    check("primary_zero", 13'(primary_control_output), 13'h041A);
    u_panel.press(CH, 14);
    check("group_long", 13'(display.group), 13'(GROUP_TUNING));
    keys_n(UP, 5);
    check("group_setup", 13'(display.group), 13'(GROUP_SETUP));
    keys_n(CH, 1);
    check("param_first", 13'(display.param), 13'(PARAM_INPUT_TYPE));
    check("type_value", display.value, 13'h0005);
    keys_n(UP, 3);
    keys_n(CH, 1);
    check("edit_menu", 13'(display.menu), 13'(MENU_EDIT));
    check("edit_blink", 13'(display.blink), 13'h0001);
    check("edit_value", display.value, 13'h041A);
    keys_n(DN, 2);
    keys_n(CH, 1);
    check("limit_saved", 13'(settings.soft_start_primary_limit), 13'h0418);
    check("saved_blink", 13'(display.blink), 13'h0000);
    keys_n(UP, 1);
    keys_n(CH, 1);
    keys_n(UP, 3);
    keys_n(CH, 1);
    check("duration", 13'(settings.soft_start_duration), 13'h0003);
    // Give the secondary fault value its own setting so a swap would show
    keys_n(DN, 2);
    keys_n(CH, 1);
    keys_n(UP, 1);
    keys_n(CH, 1);
    keys_n(BK, 1);
    check("menu_run", 13'(display.menu), 13'(MENU_RUN));
    check("clamp_on", 13'(soft_start_active), 13'h0001);
    check("clamp_value", 13'(primary_control_output), 13'h0418);
    @(posedge clk) manual_mode <= 1'b1;
    tick(2);
    check("manual", 13'(primary_control_output), 13'h0000);
    @(posedge clk) manual_mode <= 1'b0;
    dual_output <= 1'b1;
    tick(3);
    check("dual_off", 13'(soft_start_active), 13'h0000);
    check("dual_value", 13'(primary_control_output), 13'h041A);
    @(posedge clk) dual_output <= 1'b0;
    tick(3);
    check("timer_kept", 13'(soft_start_active), 13'h0001);
    @(posedge clk) input_fault_state <= 1'b1;
    tick(3);
    check("fault_pri", 13'(primary_control_output), 13'h1FCE);
    check("fault_sec", 13'(secondary_control_output), 13'h1FCF);
    @(posedge clk) input_fault_state <= 1'b0;
    tick(3);
    check("clear_sec", 13'(secondary_control_output), 13'h01F4);
    check("clear_pri", 13'(primary_control_output), 13'h0418);
    n = 0;
    while (soft_start_active === 1'b1 && n < 900) begin
      tick(1);
      n++;
    end
    // Three minutes of 200 cycles after the two reset edges
    check("end_time", 13'(cyc), 13'h025A);
    tick(1);
    check("released", 13'(primary_control_output), 13'h041A);
    wrap_up();
  end
endmodule : fault_softstart_output_limiter_tb
